// >>> hdl/tcoe_top.sv
// tcoe_top.sv: combination mode, buffer enables, output master enables
// assumes: one 100 MHz clock, plain register port, capture event is a
// one-cycle pulse synchronous to clock
//
// What this block does
// - function control reset to C0 on reset/standby
// - top two bits read one, unwritable
// - mode field selects normal, complementary, reset-sync
// - combined modes override per-channel pwm bits
// - sync bits stay effective in combined modes
// - channel 4 buffer enables at bits 3,2
// - channel 3 buffer enables at bits 1,0
// - master enable reset to FF on reset/standby
// - bits 5,4 gate channel 4 complementary pins
// - bit 3 gates channel 3 b pin
// - capture event clears enables unless disabled
// - trigger from capture a, combined modes only
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tcoe_cfg.svh"
module tcoe_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic standby,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic ch1_capture_a,
    input wire logic ch4_compl_b_wave,
    input wire logic ch4_compl_a_wave,
    input wire logic ch3_b_wave,
    input wire logic ch3_b_io_drive,
    output logic ch4_compl_b_pin_o,
    output logic ch4_compl_b_pin_oe,
    output logic ch4_compl_a_pin_o,
    output logic ch4_compl_a_pin_oe,
    output logic ch3_b_pin_o,
    output logic ch3_b_pin_oe,
    output logic combined_mode,
    output logic compl_mode,
    output logic rsync_mode,
    output logic ch4_pwm_select,
    output logic ch3_pwm_select,
    output logic ch4_sync_select,
    output logic ch3_sync_select,
    output logic ch4_buffer_b_en,
    output logic ch4_buffer_a_en,
    output logic ch3_buffer_b_en,
    output logic ch3_buffer_a_en,
    output logic sync_conflict
);
    // ----------------------------------------
    // register file
    // ----------------------------------------
    tcoe_regbus_if rb ();
    tcoe_pkg::tcoe_mode_e mode;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [2:0] pin_o_reg;
    logic [2:0] pin_oe_reg;
    wire ext_trigger_disable;
    wire trig_hit;
    assign rb.addr = addr;
    assign rb.wdata = wdata;
    assign rb.wr = wr;
    assign rb.standby = standby;
    tcoe_regs u_regs (
        .clock(clock),
        .rst(rst),
        .rb(rb)
    );
    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    assign mode = tcoe_pkg::tcoe_mode_e'(rb.func[`TCOE_CMD_HI:`TCOE_CMD_LO]);
    assign compl_mode = (mode == tcoe_pkg::TCOE_MODE_COMPL);
    assign rsync_mode = (mode == tcoe_pkg::TCOE_MODE_RSYNC);
    assign combined_mode = compl_mode || rsync_mode;
    // per-channel pwm only counts in normal operation
    assign ch4_pwm_select = rb.tmode[`TCOE_CH4_PWM_SELECT] && !combined_mode;
    assign ch3_pwm_select = rb.tmode[`TCOE_CH3_PWM_SELECT] && !combined_mode;
    // sync passes through in every mode
    assign ch4_sync_select = rb.sync[`TCOE_CH4_SYNC_SELECT];
    assign ch3_sync_select = rb.sync[`TCOE_CH3_SYNC_SELECT];
    // status only; software must avoid this case
    assign sync_conflict = compl_mode && ch4_sync_select && ch3_sync_select;
    assign ch4_buffer_b_en = rb.func[`TCOE_CH4_BUFFER_B_EN];
    assign ch4_buffer_a_en = rb.func[`TCOE_CH4_BUFFER_A_EN];
    assign ch3_buffer_b_en = rb.func[`TCOE_CH3_BUFFER_B_EN];
    assign ch3_buffer_a_en = rb.func[`TCOE_CH3_BUFFER_A_EN];
    // ----------------------------------------
    // external trigger
    // ----------------------------------------
    assign ext_trigger_disable = rb.trig[`TCOE_EXT_TRIGGER_DISABLE];
    assign trig_hit = ch1_capture_a && !ext_trigger_disable && combined_mode;
    assign rb.trig_clr = trig_hit;
    // ----------------------------------------
    // pin gating
    // ----------------------------------------
    // registered so pins never glitch on decode changes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_o_reg <= 3'h0;
            pin_oe_reg <= 3'h0;
        end else begin
            pin_o_reg <= {ch4_compl_b_wave, ch4_compl_a_wave, ch3_b_wave};
            pin_oe_reg[2] <= rb.omen[`TCOE_CH4_COMPL_B_OUT_EN] && combined_mode;
            pin_oe_reg[1] <= rb.omen[`TCOE_CH4_COMPL_A_OUT_EN] && combined_mode;
            pin_oe_reg[0] <= rb.omen[`TCOE_EB3] && (combined_mode || ch3_b_io_drive);
        end
    end
    assign ch4_compl_b_pin_o = pin_o_reg[2];
    assign ch4_compl_b_pin_oe = pin_oe_reg[2];
    assign ch4_compl_a_pin_o = pin_o_reg[1];
    assign ch4_compl_a_pin_oe = pin_oe_reg[1];
    assign ch3_b_pin_o = pin_o_reg[0];
    assign ch3_b_pin_oe = pin_oe_reg[0];
    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (rd) begin
            unique case (addr)
                `TCOE_OFF_FUNC: rdata_next = rb.func;
                `TCOE_OFF_OMEN: rdata_next = rb.omen;
                `TCOE_OFF_TMODE: rdata_next = rb.tmode;
                `TCOE_OFF_SYNC: rdata_next = rb.sync;
                `TCOE_OFF_TRIG: rdata_next = rb.trig;
                `TCOE_OFF_STAT: rdata_next = {5'h00, sync_conflict, rsync_mode, compl_mode};
                default: rdata_next = 8'h00;
            endcase
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
    assign rdata = rdata_reg;
endmodule
`default_nettype wire

// >>> hdl/tcoe_cfg.svh
// tcoe_cfg.svh: register offsets, field positions, reset values
// assumes: included by bare name from hdl files
`ifndef TCOE_CFG_SVH
`define TCOE_CFG_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define TCOE_ADDR_W 4
`define TCOE_OFF_FUNC 4'h0
`define TCOE_OFF_OMEN 4'h1
`define TCOE_OFF_TMODE 4'h2
`define TCOE_OFF_SYNC 4'h3
`define TCOE_OFF_TRIG 4'h4
`define TCOE_OFF_STAT 4'h5
// ----------------------------------------
// reset values and fixed bits
// ----------------------------------------
`define TCOE_FUNC_RST 8'hC0
`define TCOE_OMEN_RST 8'hFF
`define TCOE_TMODE_RST 8'h00
`define TCOE_SYNC_RST 8'h00
`define TCOE_TRIG_RST 8'h01
`define TCOE_TOP2_MASK 8'hC0
// ----------------------------------------
// field positions
// ----------------------------------------
`define TCOE_CMD_HI 5
`define TCOE_CMD_LO 4
`define TCOE_CH4_BUFFER_B_EN 3
`define TCOE_CH4_BUFFER_A_EN 2
`define TCOE_CH3_BUFFER_B_EN 1
`define TCOE_CH3_BUFFER_A_EN 0
`define TCOE_CH4_COMPL_B_OUT_EN 5
`define TCOE_CH4_COMPL_A_OUT_EN 4
`define TCOE_EB3 3
`define TCOE_CH4_PWM_SELECT 1
`define TCOE_CH3_PWM_SELECT 0
`define TCOE_CH4_SYNC_SELECT 1
`define TCOE_CH3_SYNC_SELECT 0
`define TCOE_EXT_TRIGGER_DISABLE 0
`endif

// >>> hdl/tcoe_pkg.sv
// tcoe_pkg.sv: types for the combination and output-enable block
// assumes: compiled before all other hdl files
package tcoe_pkg;
    typedef enum logic [1:0] {
        TCOE_MODE_NORMAL = 2'b00,
        TCOE_MODE_NORMAL1 = 2'b01,
        TCOE_MODE_COMPL = 2'b10,
        TCOE_MODE_RSYNC = 2'b11
    } tcoe_mode_e;
    typedef logic [7:0] tcoe_byte_t;
endpackage

// >>> hdl/tcoe_regbus_if.sv
// tcoe_regbus_if.sv: register access bundle between top and register file
// assumes: single clock domain
`timescale 1ns/1ns
`default_nettype none
interface tcoe_regbus_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic standby;
    logic trig_clr;
    logic [7:0] func;
    logic [7:0] omen;
    logic [7:0] tmode;
    logic [7:0] sync;
    logic [7:0] trig;
    modport regs (
        input addr, wdata, wr, standby, trig_clr,
        output func, omen, tmode, sync, trig
    );
    modport ctrl (
        output addr, wdata, wr, standby, trig_clr,
        input func, omen, tmode, sync, trig
    );
endinterface
`default_nettype wire

// >>> hdl/tcoe_regs.sv
// tcoe_regs.sv: storage of the five control registers
// assumes: write strobe one cycle; standby is a level
`timescale 1ns/1ns
`default_nettype none
`include "tcoe_cfg.svh"
module tcoe_regs (
    input wire logic clock,
    input wire logic rst,
    tcoe_regbus_if.regs rb
);
    logic [7:0] func_reg;
    logic [7:0] omen_reg;
    logic [7:0] tmode_reg;
    logic [7:0] sync_reg;
    logic [7:0] trig_reg;
    logic [7:0] omen_next;
    wire wr_func = rb.wr && (rb.addr == `TCOE_OFF_FUNC);
    wire wr_omen = rb.wr && (rb.addr == `TCOE_OFF_OMEN);
    wire wr_tmode = rb.wr && (rb.addr == `TCOE_OFF_TMODE);
    wire wr_sync = rb.wr && (rb.addr == `TCOE_OFF_SYNC);
    wire wr_trig = rb.wr && (rb.addr == `TCOE_OFF_TRIG);
    // hardware clear beats a same-cycle write
    always_comb begin
        if (rb.trig_clr) begin
            omen_next = `TCOE_TOP2_MASK;
        end else if (wr_omen) begin
            omen_next = rb.wdata | `TCOE_TOP2_MASK;
        end else begin
            omen_next = omen_reg;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            func_reg <= `TCOE_FUNC_RST;
            omen_reg <= `TCOE_OMEN_RST;
            tmode_reg <= `TCOE_TMODE_RST;
            sync_reg <= `TCOE_SYNC_RST;
            trig_reg <= `TCOE_TRIG_RST;
        end else if (rb.standby) begin
            func_reg <= `TCOE_FUNC_RST;
            omen_reg <= `TCOE_OMEN_RST;
            tmode_reg <= `TCOE_TMODE_RST;
            sync_reg <= `TCOE_SYNC_RST;
            trig_reg <= `TCOE_TRIG_RST;
        end else begin
            if (wr_func) begin
                func_reg <= rb.wdata | `TCOE_TOP2_MASK;
            end
            omen_reg <= omen_next;
            if (wr_tmode) begin
                tmode_reg <= rb.wdata;
            end
            if (wr_sync) begin
                sync_reg <= rb.wdata;
            end
            if (wr_trig) begin
                trig_reg <= rb.wdata;
            end
        end
    end
    assign rb.func = func_reg;
    assign rb.omen = omen_reg;
    assign rb.tmode = tmode_reg;
    assign rb.sync = sync_reg;
    assign rb.trig = trig_reg;
endmodule
`default_nettype wire

// >>> sim/tcoe_pin_load.sv
// tcoe_pin_load.sv: external loads on the three timer output pins
// assumes: every pin carries a pull-up; bit 2 ch4 b, bit 1 ch4 a, bit 0 ch3 b
`timescale 1ns/1ns
`default_nettype none
module tcoe_pin_load (
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe,
    output logic [2:0] level
);
    // a released pin goes to the pull-up, never keeps the last value
    assign level = (pin_o & pin_oe) | ~pin_oe;
endmodule
`default_nettype wire

// >>> sim/tcoe_checker.sv
// tcoe_checker.sv: port assertions for tcoe_top
// assumes: bound to tcoe_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module tcoe_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic standby,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic ch4_compl_b_pin_oe,
    input wire logic ch4_compl_a_pin_oe,
    input wire logic combined_mode,
    input wire logic compl_mode,
    input wire logic rsync_mode,
    input wire logic ch4_pwm_select,
    input wire logic ch3_pwm_select,
    input wire logic ch4_buffer_b_en,
    input wire logic ch4_buffer_a_en,
    input wire logic ch3_buffer_b_en,
    input wire logic ch3_buffer_a_en
);
    logic [7:0] wdata_q;
    logic [3:0] bufs;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // wdata one cycle back, since $past cannot be sliced
    always_ff @(posedge clock) wdata_q <= wdata;
    assign bufs = {ch4_buffer_b_en, ch4_buffer_a_en, ch3_buffer_b_en, ch3_buffer_a_en};
    mode_decode_a:
    assert property (combined_mode == (compl_mode | rsync_mode) && !(compl_mode && rsync_mode))
        else $error("mode decode inconsistent");
    pwm_override_a:
    assert property (combined_mode |-> !ch4_pwm_select && !ch3_pwm_select) else $error("pwm select in combined mode");
    func_write_a:
    assert property (wr && addr == 4'h0 && !standby |=> bufs == wdata_q[3:0] && compl_mode == (wdata_q[5:4] == 2'h2))
        else $error("function write not applied");
    top_bits_a:
    assert property (rd && addr <= 4'h1 |=> rdata[7:6] == 2'h3) else $error("top bits not one");
    unmapped_rd_a:
    assert property (rd && addr > 4'h5 |=> rdata == 8'h00) else $error("unmapped read not zero");
    standby_load_a:
    assert property (standby |=> bufs == 4'h0 && !combined_mode) else $error("standby reload missing");
    reset_rel_a:
    assert property ($fell(rst) |-> bufs == 4'h0 && !combined_mode) else $error("reset value wrong");
    ch4_gate_a:
    assert property (!combined_mode |=> !ch4_compl_b_pin_oe && !ch4_compl_a_pin_oe) else $error("ch4 pin driven");
endmodule
bind tcoe_top tcoe_checker i_chk (.clock, .rst, .standby, .addr, .wdata, .wr, .rd, .rdata,
    .ch4_compl_b_pin_oe, .ch4_compl_a_pin_oe, .combined_mode, .compl_mode, .rsync_mode,
    .ch4_pwm_select, .ch3_pwm_select, .ch4_buffer_b_en, .ch4_buffer_a_en, .ch3_buffer_b_en, .ch3_buffer_a_en);
`default_nettype wire

// >>> sim/tb_top.sv
// tb_top.sv: scenario bench for tcoe_top
// assumes: hdl files, pin load and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic standby = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cap = 1'b0;
    logic io_drv = 1'b0;
    logic [2:0] wave = 3'h0;
    // nets, since several dut ports drive single bits of one vector
    wire [7:0] rdata;
    wire [2:0] pin_o, pin_oe, level;
    wire cmb, cpl, rsy, p4, p3, s4, s3, sc;
    wire [3:0] bufs;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    always #5 clock = ~clock;
    tcoe_top i_dut (.clock, .rst, .standby, .addr, .wdata, .wr, .rd, .rdata, .ch1_capture_a(cap),
        .ch4_compl_b_wave(wave[2]), .ch4_compl_a_wave(wave[1]), .ch3_b_wave(wave[0]), .ch3_b_io_drive(io_drv),
        .ch4_compl_b_pin_o(pin_o[2]), .ch4_compl_b_pin_oe(pin_oe[2]), .ch4_compl_a_pin_o(pin_o[1]),
        .ch4_compl_a_pin_oe(pin_oe[1]), .ch3_b_pin_o(pin_o[0]), .ch3_b_pin_oe(pin_oe[0]),
        .combined_mode(cmb), .compl_mode(cpl), .rsync_mode(rsy), .ch4_pwm_select(p4), .ch3_pwm_select(p3),
        .ch4_sync_select(s4), .ch3_sync_select(s3), .ch4_buffer_b_en(bufs[3]), .ch4_buffer_a_en(bufs[2]),
        .ch3_buffer_b_en(bufs[1]), .ch3_buffer_a_en(bufs[0]), .sync_conflict(sc));
    tcoe_pin_load i_load (.pin_o, .pin_oe, .level);
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic pulse_cap(input logic [3:0] a, input logic w);
        @(posedge clock);
        cap <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= 8'hFF;
        @(posedge clock);
        cap <= 1'b0;
        wr <= 1'b0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd_reg(4'h0, 8'hC0);
        rd_reg(4'h1, 8'hFF);
        rd_reg(4'h9, 8'h00);
        wr_reg(4'h0, 8'h3F);
        rd_reg(4'h0, 8'hFF);
        wr_reg(4'h1, 8'h00);
        rd_reg(4'h1, 8'hC0);
    endtask
    task automatic t_mode();
        wr_reg(4'h2, 8'h03);
        wr_reg(4'h3, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr_reg(4'h0, {2'h0, m[1:0], ~m[1:0], m[1:0]});
            #1 chk({cpl, rsy, cmb, p4, p3, s4, s3, sc}, {m == 2, m == 3, m[1], ~m[1], ~m[1], 3'h2});
            chk({4'h0, bufs}, {4'h0, ~m[1:0], m[1:0]});
        end
        // both sync bits are legal only outside complementary mode
        wr_reg(4'h3, 8'h03);
        #1 chk({cpl, rsy, cmb, p4, p3, s4, s3, sc}, 8'h66);
        rd_reg(4'h5, 8'h02);
        rd_reg(4'h2, 8'h03);
        wr_reg(4'h3, 8'h00);
    endtask
    task automatic t_pins();
        wr_reg(4'h0, 8'h20);
        io_drv <= 1'b1;
        wave <= 3'h5;
        wr_reg(4'h1, 8'hFF);
        @(posedge clock);
        #1 chk({5'h0, level}, 8'h05);
        wave <= 3'h0;
        wr_reg(4'h1, 8'h08);
        @(posedge clock);
        #1 chk({5'h0, level}, 8'h06);
        wr_reg(4'h1, 8'h30);
        @(posedge clock);
        #1 chk({5'h0, level}, 8'h01);
        io_drv <= 1'b0;
        wr_reg(4'h0, 8'h00);
        @(posedge clock);
        #1 chk({5'h0, level}, 8'h07);
        io_drv <= 1'b1;
        wr_reg(4'h1, 8'hFF);
        @(posedge clock);
        #1 chk({5'h0, level}, 8'h06);
    endtask
    task automatic t_trig();
        wr_reg(4'h1, 8'hFF);
        wr_reg(4'h4, 8'h00);
        wr_reg(4'h0, 8'h30);
        pulse_cap(4'h1, 1'b1);
        rd_reg(4'h1, 8'hC0);
        wr_reg(4'h1, 8'hFF);
        wr_reg(4'h0, 8'h00);
        pulse_cap(4'h0, 1'b0);
        rd_reg(4'h1, 8'hFF);
        wr_reg(4'h0, 8'h20);
        wr_reg(4'h4, 8'h01);
        pulse_cap(4'h0, 1'b0);
        rd_reg(4'h1, 8'hFF);
        wr_reg(4'h4, 8'h00);
        pulse_cap(4'h0, 1'b0);
        rd_reg(4'h1, 8'hC0);
    endtask
    task automatic t_standby();
        wr_reg(4'h1, 8'h00);
        standby <= 1'b1;
        repeat (2) @(posedge clock);
        standby <= 1'b0;
        rd_reg(4'h0, 8'hC0);
        rd_reg(4'h1, 8'hFF);
    endtask
    task automatic results();
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // whole run needs about 100 cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 1000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_mode();
        t_pins();
        t_trig();
        t_standby();
        results();
    end
endmodule
`default_nettype wire
